/* hw/dec_defines.svh */
// Register map, field positions and reset values of the event control block
`ifndef DEC_DEFINES_SVH
`define DEC_DEFINES_SVH

`define DEC_ADDR_W        4
`define DEC_OFS_ECON      4'h0
`define DEC_OFS_STATUS    4'h4
`define DEC_OFS_MASK      4'h8
`define DEC_OFS_CTRL      4'hc

`define DEC_ABORT_SEL_HI  23
`define DEC_ABORT_SEL_LO  16
`define DEC_START_SEL_HI  15
`define DEC_START_SEL_LO  8
`define DEC_FORCE_BIT     7
`define DEC_ABORT_BIT     6
`define DEC_PAT_EN_BIT    5
`define DEC_START_EN_BIT  4
`define DEC_ABORT_EN_BIT  3

`define DEC_SEL_W         8
`define DEC_SEL_RESET     8'hff
`define DEC_STAT_W        3
`define DEC_ST_ABORT      0
`define DEC_ST_START      1
`define DEC_ST_DONE       2
`define DEC_CHANNEL_ENABLE_BIT_BIT      0
`define DEC_BUSY_BIT      1

`endif

/* hw/dec_pkg.sv */
// Types shared by the event control block
package dec_pkg;
  typedef enum logic [0:0] {
    DEC_IDLE,
    DEC_BUSY
  } dec_state_t;
endpackage

/* hw/dec_event_ctrl.sv */
// DMA channel event control: start/abort selection, forcing, pattern abort
//
// Overview of operation
// R1 - Enabled abort IRQ number in bits 23:16 aborts transfer, sets abort flag
// R2 - Start IRQ number in bits 15:8 starts a transfer when enabled
// R3 - Writing one to bit 7 forces a transfer start while the channel is enabled; reads zero
// R4 - Writing one to bit 6 aborts the transfer; reads zero
// R5 - Bit 5 set: pattern match while busy aborts and clears channel enable
// R6 - Bit 4 gates whether the start IRQ starts a cell transfer
// R7 - Bit 3 gates whether the abort IRQ terminates a transfer
// R8 - Bits 31:24 read zero and ignore writes
// R9 - Bits 2:0 read zero and ignore writes
// R10 - Simultaneous start and abort: abort wins, no transfer starts
`timescale 1ns/10ps
`include "dec_defines.svh"

module dec_event_ctrl #(
  parameter int NUM_IRQ = 256
) (
  // Clock and reset
  input  wire logic                   I_REF_CLK,
  input  wire logic                   I_SYS_RST,
  // Register port
  input  wire logic [`DEC_ADDR_W-1:0] I_ADDR,
  input  wire logic [31:0]            I_WDATA,
  input  wire logic                   I_WR,
  input  wire logic                   I_RD,
  output logic      [31:0]            O_RDATA,
  // Interrupt request sources, one level per number
  input  wire logic [NUM_IRQ-1:0]     I_IRQ,
  // Pattern match and transfer done from the channel datapath
  input  wire logic                   I_PAT_MATCH,
  input  wire logic                   I_XFER_DONE,
  // Transfer control toward the channel
  output logic                        O_XFER_START,
  output logic                        O_XFER_ABORT,
  output logic                        O_XFER_BUSY,
  output logic                        O_CHAN_EN,
  output logic                        O_ABORT_IRQ_FLAG,
  output logic                        O_IRQ
);

  // Pins are asynchronous to this clock
  logic [NUM_IRQ-1:0]         irq_s1_reg;
  logic [NUM_IRQ-1:0]         irq_s1_next;
  logic [NUM_IRQ-1:0]         irq_s2_reg;
  logic [NUM_IRQ-1:0]         irq_s2_next;
  logic [NUM_IRQ-1:0]         irq_s3_reg;
  logic [NUM_IRQ-1:0]         irq_s3_next;
  logic                       pat_s1_reg;
  logic                       pat_s1_next;
  logic                       pat_s2_reg;
  logic                       pat_s2_next;

  // Configuration state
  logic [`DEC_SEL_W-1:0]      abort_sel_reg;
  logic [`DEC_SEL_W-1:0]      abort_sel_next;
  logic [`DEC_SEL_W-1:0]      start_sel_reg;
  logic [`DEC_SEL_W-1:0]      start_sel_next;
  logic                       pat_en_reg;
  logic                       pat_en_next;
  logic                       start_en_reg;
  logic                       start_en_next;
  logic                       abort_en_reg;
  logic                       abort_en_next;
  logic                       chan_en_reg;
  logic                       chan_en_next;

  // Event and transfer state
  logic [`DEC_STAT_W-1:0]     mask_reg;
  logic [`DEC_STAT_W-1:0]     mask_next;
  logic [`DEC_STAT_W-1:0]     status_reg;
  logic [`DEC_STAT_W-1:0]     status_next;
  dec_pkg::dec_state_t        state_reg;
  dec_pkg::dec_state_t        state_next;
  logic                       busy_reg;
  logic                       busy_next;
  logic                       start_reg;
  logic                       start_next;
  logic                       abort_reg;
  logic                       abort_next;
  logic                       irq_reg;
  logic                       irq_next;
  logic [31:0]                rdata_reg;
  logic [31:0]                rdata_next;

  // Decoded strobes and events
  logic                       wr_econ;
  logic                       wr_status;
  logic                       wr_mask;
  logic                       wr_ctrl;
  logic                       irq_start_hit;
  logic                       irq_abort_hit;
  logic                       force_start;
  logic                       force_abort;
  logic                       pat_abort;
  logic                       do_abort;
  logic                       do_start;
  logic                       xfer_end;
  logic [`DEC_STAT_W-1:0]     events;

  always_comb begin
    irq_s1_next = I_IRQ;
    irq_s2_next = irq_s1_reg;
    irq_s3_next = irq_s2_reg;
    pat_s1_next = I_PAT_MATCH;
    pat_s2_next = pat_s1_reg;
  end

  always_ff @(posedge I_REF_CLK) begin
    if (I_SYS_RST) begin
      irq_s1_reg <= '0;
      irq_s2_reg <= '0;
      irq_s3_reg <= '0;
      pat_s1_reg <= 1'h0;
      pat_s2_reg <= 1'h0;
    end else begin
      irq_s1_reg <= irq_s1_next;
      irq_s2_reg <= irq_s2_next;
      irq_s3_reg <= irq_s3_next;
      pat_s1_reg <= pat_s1_next;
      pat_s2_reg <= pat_s2_next;
    end
  end

  // Rising edge of the selected line; a held level counts once
  always_comb begin
    wr_econ       = I_WR && (I_ADDR == `DEC_OFS_ECON);
    wr_status     = I_WR && (I_ADDR == `DEC_OFS_STATUS);
    wr_mask       = I_WR && (I_ADDR == `DEC_OFS_MASK);
    wr_ctrl       = I_WR && (I_ADDR == `DEC_OFS_CTRL);
    irq_start_hit = start_en_reg                              // R6
                    && irq_s2_reg[start_sel_reg]              // R2
                    && !irq_s3_reg[start_sel_reg];
    irq_abort_hit = abort_en_reg                              // R7
                    && irq_s2_reg[abort_sel_reg]              // R1
                    && !irq_s3_reg[abort_sel_reg];
    force_start   = wr_econ && I_WDATA[`DEC_FORCE_BIT];       // R3
    force_abort   = wr_econ && I_WDATA[`DEC_ABORT_BIT];       // R4
    pat_abort     = pat_en_reg && pat_s2_reg && busy_reg;     // R5
    do_abort      = irq_abort_hit || force_abort || pat_abort;
    // Abort outranks any start in the same cycle
    do_start      = (irq_start_hit || force_start)
                    && !do_abort && chan_en_reg;              // R10
    // A done beside a fresh start leaves the channel busy
    xfer_end      = busy_reg && (do_abort || (I_XFER_DONE && !do_start));
    events        = '0;
    events[`DEC_ST_ABORT] = irq_abort_hit;                    // R1
    events[`DEC_ST_START] = do_start;
    events[`DEC_ST_DONE]  = I_XFER_DONE && busy_reg;
  end

  // Bits 31:24 and 2:0 are simply not stored
  always_comb begin
    abort_sel_next = abort_sel_reg;
    start_sel_next = start_sel_reg;
    pat_en_next    = pat_en_reg;
    start_en_next  = start_en_reg;
    abort_en_next  = abort_en_reg;
    chan_en_next   = chan_en_reg;
    if (wr_econ) begin                                        // R8 R9
      abort_sel_next = I_WDATA[`DEC_ABORT_SEL_HI:`DEC_ABORT_SEL_LO];
      start_sel_next = I_WDATA[`DEC_START_SEL_HI:`DEC_START_SEL_LO];
      pat_en_next    = I_WDATA[`DEC_PAT_EN_BIT];
      start_en_next  = I_WDATA[`DEC_START_EN_BIT];
      abort_en_next  = I_WDATA[`DEC_ABORT_EN_BIT];
    end else if (wr_ctrl) begin
      chan_en_next = I_WDATA[`DEC_CHANNEL_ENABLE_BIT_BIT];
    end
    // Hardware clear wins over a software set
    if (pat_abort) begin
      chan_en_next = 1'h0;                                    // R5
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (I_SYS_RST) begin
      abort_sel_reg <= `DEC_SEL_RESET;
      start_sel_reg <= `DEC_SEL_RESET;
      pat_en_reg    <= 1'h0;
      start_en_reg  <= 1'h0;
      abort_en_reg  <= 1'h0;
      chan_en_reg   <= 1'h0;
    end else begin
      abort_sel_reg <= abort_sel_next;
      start_sel_reg <= start_sel_next;
      pat_en_reg    <= pat_en_next;
      start_en_reg  <= start_en_next;
      abort_en_reg  <= abort_en_next;
      chan_en_reg   <= chan_en_next;
    end
  end

  always_comb begin
    mask_next = mask_reg;
    if (wr_mask) begin
      mask_next = I_WDATA[`DEC_STAT_W-1:0];
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (I_SYS_RST) begin
      mask_reg <= '0;
    end else begin
      mask_reg <= mask_next;
    end
  end

  always_comb begin
    status_next = status_reg;
    if (wr_status) begin
      status_next = status_reg & ~I_WDATA[`DEC_STAT_W-1:0];
    end
    // Set beats a clear in the same cycle
    status_next = status_next | events;
    irq_next    = |(status_next & mask_reg);
  end

  always_ff @(posedge I_REF_CLK) begin
    if (I_SYS_RST) begin
      status_reg <= '0;
      irq_reg    <= 1'h0;
    end else begin
      status_reg <= status_next;
      irq_reg    <= irq_next;
    end
  end

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      dec_pkg::DEC_IDLE: begin
        if (do_start) begin
          state_next = dec_pkg::DEC_BUSY;
        end
      end
      dec_pkg::DEC_BUSY: begin
        if (xfer_end) begin                                   // R1 R4 R7
          state_next = dec_pkg::DEC_IDLE;
        end
      end
      default: begin
        state_next = dec_pkg::DEC_IDLE;
      end
    endcase
    busy_next  = (state_next == dec_pkg::DEC_BUSY);
    // Abort pulse shown even when idle so the channel can flush
    abort_next = do_abort;
    // Restart while busy is a new cell request to the channel
    start_next = do_start;
  end

  always_ff @(posedge I_REF_CLK) begin
    if (I_SYS_RST) begin
      state_reg <= dec_pkg::DEC_IDLE;
      busy_reg  <= 1'h0;
      start_reg <= 1'h0;
      abort_reg <= 1'h0;
    end else begin
      state_reg <= state_next;
      busy_reg  <= busy_next;
      start_reg <= start_next;
      abort_reg <= abort_next;
    end
  end

  // Read data stand for one cycle only, zero otherwise
  always_comb begin
    rdata_next = '0;
    if (I_RD) begin
      if (I_ADDR == `DEC_OFS_ECON) begin                      // R3 R4
        rdata_next[`DEC_ABORT_SEL_HI:`DEC_ABORT_SEL_LO] = abort_sel_reg;
        rdata_next[`DEC_START_SEL_HI:`DEC_START_SEL_LO] = start_sel_reg;
        rdata_next[`DEC_PAT_EN_BIT]   = pat_en_reg;
        rdata_next[`DEC_START_EN_BIT] = start_en_reg;
        rdata_next[`DEC_ABORT_EN_BIT] = abort_en_reg;
      end else if (I_ADDR == `DEC_OFS_STATUS) begin
        rdata_next[`DEC_STAT_W-1:0] = status_reg;
      end else if (I_ADDR == `DEC_OFS_MASK) begin
        rdata_next[`DEC_STAT_W-1:0] = mask_reg;
      end else if (I_ADDR == `DEC_OFS_CTRL) begin
        rdata_next[`DEC_CHANNEL_ENABLE_BIT_BIT] = chan_en_reg;
        rdata_next[`DEC_BUSY_BIT] = busy_reg;
      end else begin
        rdata_next = '0;
      end
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (I_SYS_RST) begin
      rdata_reg <= '0;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign O_RDATA          = rdata_reg;
  assign O_XFER_START     = start_reg;
  assign O_XFER_ABORT     = abort_reg;
  assign O_XFER_BUSY      = busy_reg;
  assign O_CHAN_EN        = chan_en_reg;
  assign O_ABORT_IRQ_FLAG = status_reg[`DEC_ST_ABORT];
  assign O_IRQ            = irq_reg;

endmodule

/* verif/dec_chk.sv */
// Port-level checks for the DMA event control block
`timescale 1ns/10ps
`include "dec_defines.svh"
module dec_chk (
  input wire logic                   I_REF_CLK,
  input wire logic                   I_SYS_RST,
  input wire logic [`DEC_ADDR_W-1:0] I_ADDR,
  input wire logic [31:0]            I_WDATA,
  input wire logic                   I_WR,
  input wire logic                   I_RD,
  input wire logic [31:0]            O_RDATA,
  input wire logic                   O_XFER_START,
  input wire logic                   O_XFER_ABORT,
  input wire logic                   O_XFER_BUSY,
  input wire logic                   O_CHAN_EN,
  input wire logic                   O_ABORT_IRQ_FLAG
);
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (I_SYS_RST);
  sequence s_rd;
    I_RD && I_ADDR == `DEC_OFS_ECON;
  endsequence
  sequence s_wr;
    I_WR && I_ADDR == `DEC_OFS_ECON;
  endsequence
  AST_RD_HI: assert property (s_rd |=> O_RDATA[31:24] == 8'h0)
    else $error("upper event bits not zero");
  AST_RD_LO: assert property (s_rd |=>
    O_RDATA[7:6] == 2'h0 && O_RDATA[2:0] == 3'h0)
    else $error("low event bits not zero");
  AST_FORCE: assert property (s_wr ##0
    (I_WDATA[`DEC_FORCE_BIT] && !I_WDATA[`DEC_ABORT_BIT]
     && O_CHAN_EN && !O_XFER_BUSY) |=> O_XFER_START)
    else $error("forced start missing");
  AST_ABORT_WR: assert property (s_wr ##0
    I_WDATA[`DEC_ABORT_BIT] |=> O_XFER_ABORT)
    else $error("written abort missing");
  AST_NO_DUAL: assert property (O_XFER_ABORT |-> !O_XFER_START)
    else $error("start beside abort");
  AST_START_BUSY: assert property (O_XFER_START |-> O_XFER_BUSY)
    else $error("start without busy");
  AST_START_EN: assert property (O_XFER_START |-> $past(O_CHAN_EN))
    else $error("start while channel off");
  AST_ABORT_FLAG: assert property ($rose(O_ABORT_IRQ_FLAG) |->
    O_XFER_ABORT || $past(O_XFER_ABORT))
    else $error("flag without abort");
endmodule

/* verif/dec_irq_src.sv */
// Model of the on-chip interrupt request sources
`timescale 1ns/10ps
module dec_irq_src (
  input  wire logic         clk,
  input  wire logic         i_req,
  input  wire logic [7:0]   i_num,
  output logic      [255:0] o_irq
);
  initial o_irq = 256'h0;
  // One request line high per occurrence, others low
  always @(posedge clk) o_irq <= i_req ? 256'h1 << i_num : 256'h0;
endmodule

/* verif/tb_top.sv */
// Self-checking bench for the DMA event control block
`timescale 1ns/10ps
module tb_top;
  logic         clk = 1'b0, rst = 1'b1, w = 1'b0, r = 1'b0;
  logic         pat = 1'b0, dn = 1'b0, p_req = 1'b0;
  logic [3:0]   ad = 4'h0;
  logic [7:0]   p_num = 8'h0;
  logic [31:0]  wd = 32'h0, rdata;
  logic [255:0] irq;
  logic         st, ab, busy, channel_enable_bit, aflag, oirq, s, a;
  int           fails = 0, checks_done = 0;
  always #12.5 clk = ~clk;
  dec_event_ctrl dut (.I_REF_CLK(clk), .I_SYS_RST(rst), .I_ADDR(ad),
    .I_WDATA(wd), .I_WR(w), .I_RD(r), .O_RDATA(rdata), .I_IRQ(irq),
    .I_PAT_MATCH(pat), .I_XFER_DONE(dn), .O_XFER_START(st),
    .O_XFER_ABORT(ab), .O_XFER_BUSY(busy), .O_CHAN_EN(channel_enable_bit),
    .O_ABORT_IRQ_FLAG(aflag), .O_IRQ(oirq));
  dec_irq_src src (.clk(clk), .i_req(p_req), .i_num(p_num), .o_irq(irq));
  task automatic chk(input string n, input logic [31:0] sn, e);
    checks_done++;
    if (sn !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", n, e, sn);
    end
  endtask
  task automatic wr(input logic [3:0] a_i, input logic [31:0] d);
    @(posedge clk);
    {w, ad, wd} <= {1'b1, a_i, d};
    @(posedge clk);
    w <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [3:0] a_i, input logic [31:0] e);
    @(posedge clk);
    {r, ad} <= {1'b1, a_i};
    @(posedge clk);
    r <= 1'b0;
    #1 chk("rdata", rdata, e);
  endtask
  // Irq or pattern event, then eight cycles of watching
  task automatic ev(input logic [7:0] n, input logic m);
    @(posedge clk);
    {p_req, p_num, pat} <= {~m, n, m};
    @(posedge clk);
    {p_req, pat} <= 2'b00;
    {s, a} = 2'b00;
    repeat (8) begin
      @(posedge clk);
      #1 {s, a} = {s | st, a | ab};
    end
  endtask
  task automatic t_regs;
    rd(4'h0, 32'h00ffff00);
    rd(4'hc, 32'h0);
    rd(4'h2, 32'h0);
    wr(4'h0, 32'hffffffff);
    rd(4'h0, 32'h00ffff38);
  endtask
  task automatic t_force;
    wr(4'hc, 32'h1);
    wr(4'h0, 32'h80);
    chk("start", {st, busy}, 2'b11);
    rd(4'hc, 32'h3);
    wr(4'h0, 32'h40);
    chk("abort", ab, 1'b1);
  endtask
  task automatic t_start;
    wr(4'h0, 32'h00002110);
    ev(8'h21, 1'b0);
    chk("irq start", s, 1'b1);
    @(posedge clk);
    dn <= 1'b1;
    @(posedge clk);
    dn <= 1'b0;
    #1 chk("done", busy, 1'b0);
    rd(4'h4, 32'h6);
    wr(4'h0, 32'h00002100);
    ev(8'h21, 1'b0);
    chk("gated start", s, 1'b0);
  endtask
  task automatic t_abort;
    wr(4'h8, 32'h1);
    rd(4'h8, 32'h1);
    wr(4'h0, 32'h00050088);
    ev(8'h05, 1'b0);
    chk("irq abort", a, 1'b1);
    chk("flag", {aflag, oirq}, 2'b11);
    wr(4'h4, 32'h1);
    wr(4'h0, 32'h00050080);
    chk("flag clr", {aflag, oirq}, 2'b00);
    ev(8'h05, 1'b0);
    chk("gated abort", {a, busy}, 2'b01);
  endtask
  task automatic t_pat;
    ev(8'h00, 1'b1);
    chk("pat off", {a, channel_enable_bit}, 2'b01);
    wr(4'h0, 32'h40);
    wr(4'h0, 32'ha0);
    ev(8'h00, 1'b1);
    chk("pat abort", {a, channel_enable_bit}, 2'b10);
  endtask
  task automatic t_both;
    wr(4'hc, 32'h1);
    wr(4'h0, 32'h00070718);
    ev(8'h07, 1'b0);
    chk("both", {s, a}, 2'b01);
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_regs;
    t_force;
    t_start;
    t_abort;
    t_pat;
    t_both;
    conclude;
  end
  initial begin
    #100000;
    fails++;
    conclude;
  end
endmodule
bind dec_event_ctrl dec_chk u_chk (.I_REF_CLK(I_REF_CLK),
  .I_SYS_RST(I_SYS_RST), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR),
  .I_RD(I_RD), .O_RDATA(O_RDATA), .O_XFER_START(O_XFER_START),
  .O_XFER_ABORT(O_XFER_ABORT), .O_XFER_BUSY(O_XFER_BUSY),
  .O_CHAN_EN(O_CHAN_EN), .O_ABORT_IRQ_FLAG(O_ABORT_IRQ_FLAG));
